/* File: fci_bus_cycle.sv */
`timescale 1ns/1ps
module fci_bus_cycle #(
   parameter int WP_CYC_P = fci_pkg::WP_CYC,
   parameter int WPH_CYC_P = fci_pkg::WPH_CYC,
   parameter int ACC_CYC_P = fci_pkg::ACC_CYC,
   parameter int DF_CYC_P = fci_pkg::DF_CYC
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic reset,
   // Request side.
   input wire logic req_valid,
   input wire fci_pkg::fci_req_t req,
   output logic req_ready,
   output logic done,
   output logic [fci_pkg::DATA_W-1:0] rd_data,
   // Flash pins.
   output fci_pkg::fci_pins_t pins,
   input wire logic [fci_pkg::DATA_W-1:0] dq_pins
);
   import fci_pkg::*;

   // Counters are four bits wide, so every phase must fit in them.
   if (WP_CYC_P < 1 || WPH_CYC_P < 1 || DF_CYC_P < 1 || ACC_CYC_P < 1 ||
       WP_CYC_P > 15 || WPH_CYC_P > 15 || DF_CYC_P > 15 || ACC_CYC_P + SYNC_DEPTH > 15) begin : g_chk
      $error("fci_bus_cycle: phase length out of range");
   end

   // Gray codes along the write path and along the read path.
   typedef enum logic [2:0] {
      B_IDLE = 3'h0,
      B_SETUP = 3'h1,
      B_STROBE = 3'h3,
      B_RECOV = 3'h2,
      B_ACCESS = 3'h4,
      B_SAMPLE = 3'h5,
      B_TURN = 3'h7
   } fci_bstate_t;

   // Whole state of the engine.
   typedef struct packed {
      fci_bstate_t st;
      logic [3:0] cnt;
      fci_pins_t pins;
      logic ready;
      logic done;
      logic [DATA_W-1:0] rd;
      logic [DATA_W-1:0] s1;
      logic [DATA_W-1:0] s2;
      logic [DATA_W-1:0] s3;
   } fci_bus_t;

   fci_bus_t cur_r; // Registered state.
   fci_bus_t cur_nxt; // Next state.

   // Sequences the strobes of one write or one read cycle.
   always_comb begin
      cur_nxt = cur_r;
      cur_nxt.done = 1'b0;
      // The first stage feeds only the second; the data bus is asynchronous.
      cur_nxt.s1 = dq_pins;
      cur_nxt.s2 = cur_r.s1;
      cur_nxt.s3 = cur_r.s2;
      cur_nxt.cnt = cur_r.cnt + 4'h1;
      unique case (cur_r.st)
         B_IDLE: begin
            cur_nxt.cnt = 4'h0;
            if (req_valid && cur_r.ready) begin
               cur_nxt.ready = 1'b0;
               cur_nxt.pins.ce_n = 1'b0;
               cur_nxt.pins.addr = req.addr;
               cur_nxt.pins.dq_out = req.data;
               cur_nxt.pins.dq_oe = req.wr;
               cur_nxt.pins.oe_n = req.wr;
               cur_nxt.st = req.wr ? B_SETUP : B_ACCESS;
            end
         end
         B_SETUP: begin
            // Address latches on the falling write strobe.
            // address then data
            cur_nxt.pins.we_n = 1'b0;
            cur_nxt.cnt = 4'h0;
            cur_nxt.st = B_STROBE;
         end
         B_STROBE: begin
            // Data latches on the rising strobe, so data stays driven past it.
            if (cur_r.cnt == 4'(WP_CYC_P - 1)) begin
               cur_nxt.pins.we_n = 1'b1;
               cur_nxt.pins.ce_n = 1'b1;
               cur_nxt.cnt = 4'h0;
               cur_nxt.st = B_RECOV;
            end
         end
         B_RECOV: begin
            cur_nxt.pins.dq_oe = 1'b0;
            if (cur_r.cnt == 4'(WPH_CYC_P - 1)) begin
               cur_nxt.done = 1'b1;
               cur_nxt.ready = 1'b1;
               cur_nxt.st = B_IDLE;
            end
         end
         B_ACCESS: begin
            // Access time plus the synchroniser depth before a sample.
            if (cur_r.cnt == 4'(ACC_CYC_P + SYNC_DEPTH - 1)) begin
               cur_nxt.st = B_SAMPLE;
            end
         end
         B_SAMPLE: begin
            // Only a value that held for two stages is taken.
            if (cur_r.s2 == cur_r.s3) begin
               cur_nxt.rd = cur_r.s3;
               cur_nxt.pins.oe_n = 1'b1;
               cur_nxt.pins.ce_n = 1'b1;
               cur_nxt.cnt = 4'h0;
               cur_nxt.st = B_TURN;
            end
         end
         B_TURN: begin
            // Lets the flash release the data bus before the next write.
            if (cur_r.cnt == 4'(DF_CYC_P - 1)) begin
               cur_nxt.done = 1'b1;
               cur_nxt.ready = 1'b1;
               cur_nxt.st = B_IDLE;
            end
         end
         default: begin
            cur_nxt.st = B_IDLE;
            cur_nxt.pins = PINS_IDLE;
            cur_nxt.ready = 1'b1;
         end
      endcase
   end

   // Registers the engine state.
   always_ff @(posedge mclk) begin
      if (reset) begin
         cur_r <= '{st: B_IDLE, cnt: 4'h0, pins: PINS_IDLE, ready: 1'b1, done: 1'b0,
            rd: 8'h00, s1: 8'h00, s2: 8'h00, s3: 8'h00};
      end else begin
         cur_r <= cur_nxt;
      end
   end

   assign req_ready = cur_r.ready;
   assign done = cur_r.done;
   assign rd_data = cur_r.rd;
   assign pins = cur_r.pins;

endmodule : fci_bus_cycle

/* File: fci_flash_model.sv */
`timescale 1ns/1ps
// Clockless flash part that reacts to strobe edges only.
module fci_flash_model
   import fci_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
   parameter logic [7:0] PART_CODE = 8'hC3, // Arbitrary value.
   parameter logic [7:0] PROT_MAP = 8'h08,
   parameter int BUSY_READS = 4,
   parameter int TMO_NS = 100000
) (
   // Pins from the host.
   input wire fci_pkg::fci_pins_t pins,
   input wire logic fail_mode,
   // Data toward the host.
   output logic [fci_pkg::DATA_W-1:0] dq
);
   // Modes: 0 array, 1 signature, 2 program, 3 erase, 4 erase timeout, 5 suspended.
   int st = 0;
   int step = 0;
   int busy = 0;
   logic [7:0] mem[int];
   logic [7:0] sel = 8'h00;
   logic [18:0] wa = '0;
   logic wce = 1'b0;
   logic tog = 1'b0;
   logic [7:0] q = 8'h00;
   realtime t0 = 0;

   // Locations never written read as erased.
   function automatic logic [7:0] arr(input logic [18:0] a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction : arr

   task automatic finish_op();
      int ks[$];
      if (st == 3) begin
         foreach (mem[k]) begin
            if (sel[k[18:16]] && !PROT_MAP[k[18:16]]) ks.push_back(k);
         end
         foreach (ks[i]) begin
            mem[ks[i]] = 8'h00;
            mem.delete(ks[i]);
         end
      end
      st = 0;
   endtask : finish_op

   task automatic wr(input logic [18:0] a, input logic [7:0] d);
      int nx = 0;
      if (st < 2 && step == 6) begin
         if (!fail_mode) mem[a] = arr(a) & d;
         st = 2;
         busy = BUSY_READS;
      end else if (d == READ_RESET_CMD) begin
         st = 0;
      end else if (st == 3) begin
         if (d == WIPE_PAUSE_CMD && sel != 8'hFF) st = 5;
      end else if (st == 4 && d == BLOCK_WIPE_CMD) begin
         sel[a[18:16]] = 1'b1;
         t0 = $realtime;
      end else if (st == 4 && d == WIPE_PAUSE_CMD) begin
         st = 5;
      end else if (st == 5 && d == WIPE_CONTINUE_CMD) begin
         st = 3;
         busy = BUSY_READS;
      end else if (st >= 2) begin
         nx = 0;
      end else if ((step == 0 || step == 3) && a == UNLOCK_ADDR1 && d == UNLOCK_DATA1) begin
         nx = step + 1;
      end else if ((step == 1 || step == 4) && a == UNLOCK_ADDR2 && d == UNLOCK_DATA2) begin
         nx = step + 1;
      end else if (step == 2 && a == UNLOCK_ADDR1 && d == SIGNATURE_READ_CMD) begin
         st = 1;
      end else if (step == 2 && a == UNLOCK_ADDR1 && d == BYTE_WRITE_CMD) begin
         nx = 6;
      end else if (step == 2 && a == UNLOCK_ADDR1 && d == ERASE_SETUP_CMD) begin
         nx = 3;
      end else if (step == 5 && a == UNLOCK_ADDR1 && d == CHIP_WIPE_CMD) begin
         sel = 8'hFF;
         st = 3;
         busy = BUSY_READS;
      end else if (step == 5 && d == BLOCK_WIPE_CMD) begin
         sel = 8'h00;
         sel[a[18:16]] = 1'b1;
         st = 4;
         t0 = $realtime;
      end else begin
         st = 0;
      end
      step = nx;
   endtask : wr

   // A released bus shows the inverse of the last byte, so a stale sample cannot pass.
   assign dq = (!pins.ce_n && !pins.oe_n) ? q : (pins.dq_oe ? pins.dq_out : ~q);

   always @(negedge pins.we_n) begin
      wa = pins.addr;
      wce = !pins.ce_n;
   end

   always @(posedge pins.we_n) begin
      if (wce) wr(wa, pins.dq_out);
   end

   always @(negedge pins.oe_n) begin
      if (st == 4 && $realtime - t0 >= TMO_NS) begin
         st = 3;
         busy = BUSY_READS;
      end
      if (st >= 2 && st <= 4) begin
         tog = ~tog;
         q = {1'b0, tog, fail_mode, 1'b0, (st != 4), 3'b000};
         if (!fail_mode && st != 4) begin
            busy = busy - 1;
            if (busy == 0) finish_op();
         end
      end else if (st == 1) begin
         q = pins.addr[0] ? PART_CODE : (pins.addr[1] ? {7'h00, PROT_MAP[pins.addr[18:16]]} : MAKER_CODE);
      end else begin
         q = arr(pins.addr);
      end
   end
endmodule : fci_flash_model

/* File: fci_host.sv */
`timescale 1ns/1ps
module fci_host (
   // Clock and reset.
   input wire logic mclk,
   input wire logic reset,
   // User order port.
   input wire logic cmd_valid,
   input wire fci_pkg::fci_cmd_t cmd,
   output logic cmd_ready,
   // User answer port.
   output logic rsp_valid,
   output logic [fci_pkg::DATA_W-1:0] rsp_data,
   output logic rsp_fail,
   // Flash pins.
   output fci_pkg::fci_pins_t flash_pins,
   input wire logic [fci_pkg::DATA_W-1:0] flash_dq
);
   import fci_pkg::*;

   // Gray codes along write then poll path; codes 4 and 5 are illegal.
   typedef enum logic [2:0] {
      M_IDLE = 3'h0,
      M_WRITE = 3'h1,
      M_WWAIT = 3'h3,
      M_READ = 3'h2,
      M_RWAIT = 3'h6,
      M_RESP = 3'h7
   } fci_mstate_t;

   // Whole state of the sequencer.
   typedef struct packed {
      fci_mstate_t st;
      fci_cmd_t cmd;
      logic [2:0] idx;
      logic [1:0] pn;
      logic [DATA_W-1:0] prev;
      logic failed;
      logic cmd_ready;
      logic rsp_valid;
      logic [DATA_W-1:0] rsp_data;
      logic rsp_fail;
      logic req_valid;
      fci_req_t req;
   } fci_host_t;

   fci_host_t cur_r; // Registered state.
   fci_host_t cur_nxt; // Next state.
   logic eng_ready; // Engine can take a cycle.
   logic eng_done; // Engine finished a cycle.
   logic [DATA_W-1:0] eng_rd; // Byte of the last read.

   // Number of write cycles each order sends.
   function automatic logic [2:0] seq_len(input fci_op_t op);
      unique case (op)
         OP_BYTE_WRITE: return 3'h4;
         OP_CHIP_WIPE, OP_BLOCK_WIPE: return 3'h6;
         OP_SIGNATURE: return 3'h3;
         OP_RESET, OP_BLOCK_ADD, OP_WIPE_PAUSE, OP_WIPE_CONTINUE: return 3'h1;
         default: return 3'h0;
      endcase
   endfunction : seq_len

   // Address and data of write cycle i of an order.
   function automatic fci_req_t seq_word(input fci_cmd_t c, input logic [2:0] i);
      fci_req_t r;
      r.wr = 1'b1;
      r.addr = UNLOCK_ADDR1;
      r.data = UNLOCK_DATA1;
      if (i == 3'h1 || i == 3'h4) begin
         r.addr = UNLOCK_ADDR2;
         r.data = UNLOCK_DATA2;
      end
      if (i == 3'h0) begin
         // Single-word orders need no unlock; a lone word is the command.
         unique case (c.op)
            OP_RESET: begin
               r.addr = c.addr;
               r.data = READ_RESET_CMD;
            end
            OP_BLOCK_ADD: begin
               r.addr = c.addr;
               r.data = BLOCK_WIPE_CMD;
            end
            OP_WIPE_PAUSE: begin
               r.addr = c.addr;
               r.data = WIPE_PAUSE_CMD;
            end
            OP_WIPE_CONTINUE: begin
               r.addr = c.addr;
               r.data = WIPE_CONTINUE_CMD;
            end
            default: begin
            end
         endcase
      end else if (i == 3'h2) begin
         if (c.op == OP_SIGNATURE) begin
            r.data = SIGNATURE_READ_CMD;
         end else if (c.op == OP_BYTE_WRITE) begin
            r.data = BYTE_WRITE_CMD;
         end else begin
            r.data = ERASE_SETUP_CMD;
         end
      end else if (i == 3'h3 && c.op == OP_BYTE_WRITE) begin
         r.addr = c.addr;
         r.data = c.data;
      end else if (i == 3'h5) begin
         if (c.op == OP_CHIP_WIPE) begin
            r.data = CHIP_WIPE_CMD;
         end else begin
            r.addr = c.addr;
            r.data = BLOCK_WIPE_CMD;
         end
      end
      return r;
   endfunction : seq_word

   // Orders whose end is found by polling the status flags.
   function automatic logic is_poll(input fci_op_t op);
      return (op == OP_BYTE_WRITE || op == OP_CHIP_WIPE || op == OP_WIPE_PAUSE || op == OP_POLL);
   endfunction : is_poll

   // Walks an order's write cycles, then its reads, then answers.
   always_comb begin
      cur_nxt = cur_r;
      cur_nxt.rsp_valid = 1'b0;
      unique case (cur_r.st)
         M_IDLE: begin
            cur_nxt.cmd_ready = 1'b1;
            if (cmd_valid && cur_r.cmd_ready) begin
               // Orders are taken only here, so nothing but the order just
               // sent can reach the flash while its engine runs.
               // one order at a time
               cur_nxt.cmd_ready = 1'b0;
               cur_nxt.cmd = cmd;
               cur_nxt.idx = 3'h0;
               cur_nxt.pn = 2'h0;
               cur_nxt.failed = 1'b0;
               cur_nxt.st = (seq_len(cmd.op) == 3'h0) ? M_READ : M_WRITE;
            end
         end
         M_WRITE: begin
            cur_nxt.req_valid = 1'b1;
            cur_nxt.req = seq_word(cur_r.cmd, cur_r.idx);
            if (cur_r.req_valid && eng_ready) begin
               cur_nxt.req_valid = 1'b0;
               cur_nxt.st = M_WWAIT;
            end
         end
         M_WWAIT: begin
            if (eng_done) begin
               if (cur_r.idx == seq_len(cur_r.cmd.op) - 3'h1) begin
                  if (!cur_r.failed && (cur_r.cmd.op == OP_SIGNATURE || is_poll(cur_r.cmd.op))) begin
                     cur_nxt.st = M_READ;
                  end else begin
                     cur_nxt.rsp_data = 8'h00;
                     cur_nxt.rsp_fail = cur_r.failed;
                     cur_nxt.st = M_RESP;
                  end
               end else begin
                  cur_nxt.idx = cur_r.idx + 3'h1;
                  cur_nxt.st = M_WRITE;
               end
            end
         end
         M_READ: begin
            cur_nxt.req_valid = 1'b1;
            cur_nxt.req = '{wr: 1'b0, addr: cur_r.cmd.addr, data: 8'h00};
            if (cur_r.req_valid && eng_ready) begin
               cur_nxt.req_valid = 1'b0;
               cur_nxt.st = M_RWAIT;
            end
         end
         M_RWAIT: begin
            if (eng_done) begin
               if (!is_poll(cur_r.cmd.op)) begin
                  cur_nxt.rsp_data = eng_rd;
                  cur_nxt.rsp_fail = 1'b0;
                  cur_nxt.st = M_RESP;
               end else if (cur_r.pn == 2'h0) begin
                  cur_nxt.prev = eng_rd;
                  cur_nxt.pn = 2'h1;
                  cur_nxt.st = M_READ;
               end else if (cur_r.prev[TOGGLE_FLAG_BIT] == eng_rd[TOGGLE_FLAG_BIT]) begin
                  cur_nxt.rsp_data = eng_rd;
                  cur_nxt.rsp_fail = 1'b0;
                  cur_nxt.st = M_RESP;
               end else if (cur_r.pn == 2'h2) begin
                  // Still toggling after the fail flag: the flash gave up.
                  // reset after failure
                  cur_nxt.failed = 1'b1;
                  cur_nxt.cmd.op = OP_RESET;
                  cur_nxt.idx = 3'h0;
                  cur_nxt.st = M_WRITE;
               end else begin
                  cur_nxt.prev = eng_rd;
                  cur_nxt.pn = eng_rd[FAIL_FLAG_BIT] ? 2'h2 : 2'h1;
                  cur_nxt.st = M_READ;
               end
            end
         end
         M_RESP: begin
            cur_nxt.rsp_valid = 1'b1;
            cur_nxt.cmd_ready = 1'b1;
            cur_nxt.st = M_IDLE;
         end
         default: begin
            cur_nxt.st = M_IDLE;
            cur_nxt.req_valid = 1'b0;
         end
      endcase
   end

   // Registers the sequencer state.
   always_ff @(posedge mclk) begin
      if (reset) begin
         cur_r <= '{st: M_IDLE, cmd: '{op: OP_READ, addr: 19'h00000, data: 8'h00}, idx: 3'h0, pn: 2'h0,
            prev: 8'h00, failed: 1'b0, cmd_ready: 1'b0, rsp_valid: 1'b0, rsp_data: 8'h00, rsp_fail: 1'b0,
            req_valid: 1'b0, req: '{wr: 1'b0, addr: 19'h00000, data: 8'h00}};
      end else begin
         cur_r <= cur_nxt;
      end
   end

   // Cycle engine that shapes the strobes and samples the data pins.
   fci_bus_cycle u_cycle (
      .mclk(mclk),
      .reset(reset),
      .req_valid(cur_r.req_valid),
      .req(cur_r.req),
      .req_ready(eng_ready),
      .done(eng_done),
      .rd_data(eng_rd),
      .pins(flash_pins),
      .dq_pins(flash_dq)
   );

   assign cmd_ready = cur_r.cmd_ready;
   assign rsp_valid = cur_r.rsp_valid;
   assign rsp_data = cur_r.rsp_data;
   assign rsp_fail = cur_r.rsp_fail;

endmodule : fci_host

/* File: fci_host_bench.sv */
`timescale 1ns/1ps
module fci_host_bench;
   import fci_pkg::*;

   // Identity bytes are arbitrary; sector 3 is protected.
   localparam logic [7:0] MAKER = 8'h5A;
   localparam logic [7:0] PART = 8'hC3;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic cmd_valid = 1'b0;
   fci_cmd_t cmd = '0;
   logic cmd_ready;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic rsp_fail;
   fci_pins_t flash_pins;
   logic [7:0] flash_dq;
   logic fail_mode = 1'b0;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;
   // Shadow of the array; a missing key reads as erased.
   logic [7:0] sh[int];
   logic [18:0] a1, a2, a3;
   logic [7:0] d1, d2;
   logic [18:0] sig_a[4] = '{19'h00000, 19'h00001, 19'h30002, 19'h00002};
   logic [7:0] sig_e[4] = '{MAKER, PART, 8'h01, 8'h00};

   fci_host fci_host_inst (.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail), .flash_pins(flash_pins),
      .flash_dq(flash_dq));
   fci_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .PROT_MAP(8'h08)) fci_flash_model_inst (
      .pins(flash_pins), .fail_mode(fail_mode), .dq(flash_dq));

   always #50 mclk = ~mclk;

   function automatic logic [7:0] exp_rd(input logic [18:0] a);
      return sh.exists(a) ? sh[a] : 8'hFF;
   endfunction : exp_rd

   task automatic complete_run();
      if (n_mismatch == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [7:0] seen, input logic [7:0] expv);
      checks++;
      if (seen !== expv) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expv);
      end
   endtask : check

   // Hands one order over, waits for its answer and compares it; failures skip the data byte.
   task automatic do_op(input fci_op_t op, input logic [18:0] a, input logic [7:0] d, input logic [7:0] ed,
      input logic ef);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd <= '{op: op, addr: a, data: d};
      do @(negedge mclk); while (cmd_ready !== 1'b1);
      @(posedge mclk);
      cmd_valid <= 1'b0;
      do @(negedge mclk); while (rsp_valid !== 1'b1);
      if (!ef) check(rsp_data, ed);
      check({7'h00, rsp_fail}, {7'h00, ef});
   endtask : do_op

   // A hang is cut short well past the longest expected run.
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_mismatch++;
         complete_run();
      end
   end

   initial begin
      void'($urandom(61048));
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      a1 = {3'h2, 16'($urandom)};
      a2 = {3'h6, 16'($urandom)};
      a3 = {3'h1, 16'($urandom)};
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      do_op(OP_READ, a1, 8'h00, exp_rd(a1), 1'b0);
      sh[a1] = d1;
      do_op(OP_BYTE_WRITE, a1, d1, exp_rd(a1), 1'b0);
      sh[a1] = d1 & d2;
      do_op(OP_BYTE_WRITE, a1, d2, exp_rd(a1), 1'b0);
      sh[a2] = d2;
      do_op(OP_BYTE_WRITE, a2, d2, exp_rd(a2), 1'b0);
      // Both identity places and the protection places of sectors 3 and 0, each left by a reset write.
      for (int i = 0; i < 4; i++) begin
         do_op(OP_SIGNATURE, sig_a[i], 8'h00, sig_e[i], 1'b0);
         do_op(OP_RESET, 19'h00000, 8'h00, 8'h00, 1'b0);
      end
      do_op(OP_READ, a1, 8'h00, exp_rd(a1), 1'b0);
      // Sector erase with an added sector, paused inside the timeout and resumed.
      do_op(OP_BLOCK_WIPE, a1, 8'h00, 8'h00, 1'b0);
      do_op(OP_BLOCK_ADD, 19'h50100, 8'h00, 8'h00, 1'b0);
      do_op(OP_WIPE_PAUSE, 19'h00010, 8'h00, 8'hFF, 1'b0);
      do_op(OP_WIPE_CONTINUE, 19'h00010, 8'h00, 8'h00, 1'b0);
      do_op(OP_POLL, 19'h00010, 8'h00, 8'hFF, 1'b0);
      sh.delete(a1);
      do_op(OP_READ, a1, 8'h00, exp_rd(a1), 1'b0);
      do_op(OP_READ, a2, 8'h00, exp_rd(a2), 1'b0);
      do_op(OP_CHIP_WIPE, 19'h00020, 8'h00, 8'hFF, 1'b0);
      sh.delete();
      do_op(OP_READ, a2, 8'h00, exp_rd(a2), 1'b0);
      // The flash reports a failure; the host must reset it and report.
      @(posedge mclk);
      fail_mode <= 1'b1;
      do_op(OP_BYTE_WRITE, a3, d1, 8'h00, 1'b1);
      @(posedge mclk);
      fail_mode <= 1'b0;
      do_op(OP_READ, a3, 8'h00, exp_rd(a3), 1'b0);
      complete_run();
   end
endmodule : fci_host_bench

/* File: fci_host_sva.sv */
`timescale 1ns/1ps
// Checks the write and read cycles that the host puts on the flash pins.
module fci_host_sva
   import fci_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic reset,
   // User order port.
   input wire logic cmd_valid,
   input wire fci_pkg::fci_cmd_t cmd,
   input wire logic cmd_ready,
   // User answer port.
   input wire logic rsp_valid,
   input wire logic [fci_pkg::DATA_W-1:0] rsp_data,
   input wire logic rsp_fail,
   // Flash pins.
   input wire fci_pkg::fci_pins_t flash_pins,
   input wire logic [fci_pkg::DATA_W-1:0] flash_dq
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (reset);

   // Index of the write within the current order, so each bus write is tied to its place.
   logic [3:0] wr_idx_r;
   fci_op_t op_r;
   logic [ADDR_W-1:0] ca_r;
   logic [DATA_W-1:0] cd_r;
   logic [DATA_W-1:0] last_d_r;
   wire take = cmd_valid && cmd_ready;
   wire [ADDR_W-1:0] pa = flash_pins.addr;
   wire [DATA_W-1:0] pd = flash_pins.dq_out;
   wire wf = !flash_pins.we_n;
   wire multi = op_r inside {OP_SIGNATURE, OP_BYTE_WRITE, OP_CHIP_WIPE, OP_BLOCK_WIPE};
   wire erase = op_r inside {OP_CHIP_WIPE, OP_BLOCK_WIPE};

   // Latches the order and counts its writes on falling write strobes.
   always_ff @(posedge mclk) begin
      if (reset) begin
         wr_idx_r <= 4'h0;
         op_r <= OP_READ;
         ca_r <= '0;
         cd_r <= '0;
         last_d_r <= '0;
      end else begin
         if (take) begin
            wr_idx_r <= 4'h0;
            op_r <= cmd.op;
            ca_r <= cmd.addr;
            cd_r <= cmd.data;
         end else if ($fell(flash_pins.we_n) && wr_idx_r != 4'hF) begin
            wr_idx_r <= wr_idx_r + 4'h1;
         end
         if ($rose(flash_pins.we_n)) last_d_r <= pd;
      end
   end

   sequence read_hold;
      (!flash_pins.oe_n && !flash_pins.ce_n)[*5];
   endsequence
   sequence write_release;
      flash_pins.we_n && flash_pins.dq_oe && $stable(pd) && $stable(pa);
   endsequence

   strobe_pair_a: assert property (wf |-> !flash_pins.ce_n && flash_pins.oe_n && flash_pins.dq_oe)
      else $error("write strobe without chip select");
   addr_setup_a: assert property ($fell(flash_pins.we_n) |-> $stable(pa) && $stable(pd))
      else $error("address moved at strobe fall");
   data_hold_a: assert property ($fell(flash_pins.we_n) |=> write_release)
      else $error("data not held past strobe rise");
   read_hold_a: assert property ($fell(flash_pins.oe_n) |-> read_hold ##[0:8] flash_pins.oe_n)
      else $error("read cycle length wrong");
   ready_drop_a: assert property (take |=> !cmd_ready [*6])
      else $error("ready during order");
   unlock_first_a: assert property ($fell(flash_pins.we_n) &&
      ((multi && wr_idx_r == 0) || (erase && wr_idx_r == 3)) |-> pa == UNLOCK_ADDR1 && pd == UNLOCK_DATA1)
      else $error("first unlock write wrong");
   unlock_second_a: assert property ($fell(flash_pins.we_n) &&
      ((multi && wr_idx_r == 1) || (erase && wr_idx_r == 4)) |-> pa == UNLOCK_ADDR2 && pd == UNLOCK_DATA2)
      else $error("second unlock write wrong");
   setup_cmd_a: assert property ($fell(flash_pins.we_n) && multi && wr_idx_r == 2 |->
      pa == UNLOCK_ADDR1 &&
      pd == (op_r == OP_SIGNATURE ? SIGNATURE_READ_CMD : (erase ? ERASE_SETUP_CMD : BYTE_WRITE_CMD)))
      else $error("third write wrong");
   confirm_cmd_a: assert property ($fell(flash_pins.we_n) && erase && wr_idx_r == 5 |->
      (op_r == OP_CHIP_WIPE ? (pa == UNLOCK_ADDR1 && pd == CHIP_WIPE_CMD) : (pa == ca_r && pd == BLOCK_WIPE_CMD)))
      else $error("erase confirm wrong");
   prog_data_a: assert property ($fell(flash_pins.we_n) && op_r == OP_BYTE_WRITE && wr_idx_r == 3
      |-> pa == ca_r && pd == cd_r)
      else $error("program data write wrong");
   single_write_a: assert property ($fell(flash_pins.we_n) && wr_idx_r == 0 && !multi &&
      op_r != OP_POLL && op_r != OP_READ |-> pa == ca_r && pd == (op_r == OP_RESET ? READ_RESET_CMD :
      (op_r == OP_WIPE_PAUSE ? WIPE_PAUSE_CMD : BLOCK_WIPE_CMD)))
      else $error("single command write wrong");
   fail_reset_a: assert property (rsp_valid && rsp_fail |-> last_d_r == READ_RESET_CMD)
      else $error("failure answered without reset write");
endmodule : fci_host_sva

bind fci_host fci_host_sva fci_host_sva_inst (.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
   .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail),
   .flash_pins(flash_pins), .flash_dq(flash_dq));

/* File: fci_pkg.sv */
package fci_pkg;

   // Bus widths of the flash part.
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;

   // Clock period of mclk, 10 MHz.
   localparam int CLK_PERIOD_NS = 100;

   // Least write-strobe low time.
   localparam int T_WP_NS = 50;
   // Least write-strobe high time between writes.
   localparam int T_WPH_NS = 20;
   // Longest address-to-data access time.
   localparam int T_ACC_NS = 150;
   // Longest output-disable to high impedance time.
   localparam int T_DF_NS = 35;

   // Rounds a least time up to whole cycles, never below one.
   function automatic int cyc_up(input int t_ns);
      int c;
      c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_up

   localparam int WP_CYC = cyc_up(T_WP_NS);
   localparam int WPH_CYC = cyc_up(T_WPH_NS);
   localparam int ACC_CYC = cyc_up(T_ACC_NS);
   localparam int DF_CYC = cyc_up(T_DF_NS);
   // Flip-flops on the data pins before a sample is trusted.
   localparam int SYNC_DEPTH = 3;

   // Unlock pair addresses and data.
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 19'h05555;
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 19'h02AAA;
   localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 8'hAA;
   localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h55;

   // Command bytes.
   localparam logic [DATA_W-1:0] READ_RESET_CMD = 8'hF0;
   localparam logic [DATA_W-1:0] SIGNATURE_READ_CMD = 8'h90;
   localparam logic [DATA_W-1:0] ERASE_SETUP_CMD = 8'h80;
   localparam logic [DATA_W-1:0] CHIP_WIPE_CMD = 8'h10;
   localparam logic [DATA_W-1:0] BLOCK_WIPE_CMD = 8'h30;
   localparam logic [DATA_W-1:0] BYTE_WRITE_CMD = 8'hA0;
   localparam logic [DATA_W-1:0] WIPE_PAUSE_CMD = 8'hB0;
   localparam logic [DATA_W-1:0] WIPE_CONTINUE_CMD = 8'h30;

   // Status flag positions on the data bus.
   localparam int POLL_FLAG_BIT = 7;
   localparam int TOGGLE_FLAG_BIT = 6;
   localparam int FAIL_FLAG_BIT = 5;
   localparam int ERASE_TIMER_FLAG = 3;

   // Orders taken at the user port.
   typedef enum logic [3:0] {
      OP_READ = 4'h0,
      OP_RESET = 4'h1,
      OP_SIGNATURE = 4'h2,
      OP_BYTE_WRITE = 4'h3,
      OP_CHIP_WIPE = 4'h4,
      OP_BLOCK_WIPE = 4'h5,
      OP_BLOCK_ADD = 4'h6,
      OP_WIPE_PAUSE = 4'h7,
      OP_WIPE_CONTINUE = 4'h8,
      OP_POLL = 4'h9
   } fci_op_t;

   // One user order.
   typedef struct packed {
      fci_op_t op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fci_cmd_t;

   // One bus cycle request to the cycle engine.
   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fci_req_t;

   // Pins driven toward the flash; strobes are active low.
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
   } fci_pins_t;

   localparam fci_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
      addr: 19'h00000, dq_out: 8'h00, dq_oe: 1'b0};

endpackage : fci_pkg
